// ### logic/acx_core.sv
/* acx_core: executes accumulator clear with prefetch and write-back,
   watchdog restart and bitwise inversion; owns W0..W15, both
   accumulators, status flags and the watchdog counters.
   Assumes a data memory that answers a read in the cycle in which
   the request stands, and a register master that never waits. */
// Functional notes
// RL1 - Accumulator clear zeroes all 40 bits of the chosen accumulator.
// RL2 - Clear also drops that accumulator's overflow and clip flags only.
// RL3 - Accumulator clear is known by its upper opcode byte with bit 14 clear.
// RL4 - Optional X/Y prefetch via W8/W9, W10/W11 into W4..W7, step -6..6.
// RL5 - Optional rounded store of other accumulator to W13 or [W13]+=2.
// RL6 - Select bit picks write-back source; fields pick prefetch and store.
// RL7 - Watchdog restart zeroes count and both prescaler counts, no flags.
// RL8 - Watchdog restart leaves prescaler ratio settings alone.
// RL9 - Watchdog restart has one fixed encoding and takes one cycle.
// RL10 - File inversion writes ones' complement to W0 or the file register.
// RL11 - Size bit: word when 0, byte when 1 touches low byte only.
// RL12 - Inversions update only negative and zero flags from the result.
// RL13 - File inversion carries a 13-bit file address.
// RL14 - Default working register is W0.
// RL15 - File inversion has a single execute cycle.
// RL16 - Working inversion supports all six modes on source and dest.
// RL17 - Clear with no prefetch and no store touches no W or memory.
`include "acx_map.svh"
`timescale 1ns/100ps
`default_nettype none
module acx_core import acx_pkg::*; (
  input wire logic MCLK,
  input wire logic RST_B,
  input wire logic INSTR_VALID,
  input wire logic [23:0] INSTR,
  output logic INSTR_READY,
  output logic EXEC_DONE,
  output var acx_mem_s MEM_REQ,
  input wire logic [15:0] MEM_RDATA,
  input wire logic [7:0] BUS_ADDR,
  input wire logic [15:0] BUS_WDATA,
  input wire logic BUS_WR,
  input wire logic BUS_RD,
  output logic [15:0] BUS_RDATA
);
  localparam logic [3:0] W_DEF = 4'h0;
  localparam logic [3:0] W_OFS = 4'hC;
  localparam logic [3:0] W_WB = 4'hD;
  localparam logic [2:0] AM_DIR = 3'h0;
  localparam logic [2:0] AM_PSD = 3'h2;
  localparam logic [2:0] AM_PSI = 3'h3;
  localparam logic [2:0] AM_PRD = 3'h4;
  localparam logic [2:0] AM_PRI = 3'h5;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Prefetch code to pointer step; codes 0, 4, 8, C do not move
  function automatic logic [15:0] pf_step(input logic [3:0] c);
    logic [15:0] s;
    s = 16'h0000;
    case (c[2:0])
      3'h1: s = 16'h0002;
      3'h2: s = 16'h0004;
      3'h3: s = 16'h0006;
      3'h5: s = 16'hFFFA;
      3'h6: s = 16'hFFFC;
      3'h7: s = 16'hFFFE;
      default: s = 16'h0000;
    endcase
    return s;
  endfunction

  function automatic logic [15:0] am_step(input logic [2:0] m, input logic b);
    logic [15:0] sz;
    sz = b ? 16'h0001 : 16'h0002;
    if (m == AM_PSI || m == AM_PRI) begin
      return sz;
    end
    if (m == AM_PSD || m == AM_PRD) begin
      return 16'h0000 - sz;
    end
    return 16'h0000;
  endfunction

  // Pre-modify modes address the moved pointer
  function automatic logic [15:0] am_ea(input logic [2:0] m, input logic b,
                                        input logic [15:0] w);
    return (m == AM_PRD || m == AM_PRI) ? w + am_step(m, b) : w;
  endfunction

  function automatic logic [15:0] merge(input logic b, input logic [15:0] old,
                                        input logic [15:0] nw);
    return b ? {old[15:8], nw[7:0]} : nw;
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [15:0] w_ff [16];
  logic [39:0] acc_a_ff;
  logic [39:0] acc_b_ff;
  acx_sr_s sr_ff;
  acx_state_e st_ff;
  acx_state_e nxt_st;
  acx_dec_s dec_ff;
  acx_dec_s dec_in;
  acx_mem_s nxt_mem;
  logic [15:0] opa_ff;
  logic [15:0] opb_ff;
  logic lane_ff;
  logic [3:0] cfg_ff;
  logic [15:0] wdt_cnt_ff;
  logic [6:0] pra_ff;
  logic [2:0] prb_ff;
  logic [15:0] rd_mux;

  acx_decode u_dec (
    .instr(INSTR),
    .dec(dec_in)
  );

  // ----------------------------------------
  // Sequencing
  // ----------------------------------------
  wire logic accept = INSTR_VALID && INSTR_READY;
  wire logic multi = dec_in.op inside {ACX_ACC, ACX_INVF, ACX_INVW};
  wire logic in_exec = st_ff == ST_EXEC;
  wire logic do_acc = in_exec && dec_ff.op == ACX_ACC;
  wire logic do_invf = in_exec && dec_ff.op == ACX_INVF;
  wire logic do_invw = in_exec && dec_ff.op == ACX_INVW;
  wire logic wdt_clear = accept && dec_in.op == ACX_WDT; // RL9

  // Every multi-cycle class walks RDX, RDY, EXEC; results land in EXEC
  always_comb begin
    nxt_st = st_ff;
    unique case (st_ff)
      ST_IDLE: nxt_st = (accept && multi) ? ST_RDX : ST_IDLE;
      ST_RDX: nxt_st = ST_RDY;
      ST_RDY: nxt_st = ST_EXEC;
      ST_EXEC: nxt_st = ST_IDLE; // RL15
    endcase
  end

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      st_ff <= ST_IDLE;
      INSTR_READY <= 1'b1;
      EXEC_DONE <= 1'b0;
      dec_ff <= '0;
    end else begin
      st_ff <= nxt_st;
      INSTR_READY <= nxt_st == ST_IDLE;
      EXEC_DONE <= in_exec || (accept && !multi);
      if (accept) begin
        dec_ff <= dec_in;
      end
    end
  end

  // ----------------------------------------
  // Operand addresses and memory requests
  // ----------------------------------------
  wire logic [3:0] xp_in = {3'b100, dec_in.xop[3]};
  wire logic [3:0] xp = {3'b100, dec_ff.xop[3]};
  wire logic [3:0] yp = {3'b101, dec_ff.yop[3]};
  wire logic x_on = dec_ff.xop != `ACX_PF_NONE;
  wire logic y_on = dec_ff.yop != `ACX_PF_NONE;
  wire logic wb_dir = dec_ff.wb == `ACX_WB_DIR;
  wire logic wb_ind = dec_ff.wb == `ACX_WB_IND;
  wire logic [15:0] xa = dec_in.xop == `ACX_PF_REG ? w_ff[xp_in] + w_ff[W_OFS] :
                         w_ff[xp_in]; // RL4
  wire logic [15:0] ya = dec_ff.yop == `ACX_PF_REG ? w_ff[yp] + w_ff[W_OFS] : w_ff[yp];
  wire logic [15:0] rx_addr = dec_in.op == ACX_INVF ? {3'b000, dec_in.fadr} : // RL13
                              dec_in.op == ACX_INVW ?
                              am_ea(dec_in.ps, dec_in.byte_m, w_ff[dec_in.sreg]) : xa;
  wire logic rd_x = accept && ((dec_in.op == ACX_ACC && dec_in.xop != `ACX_PF_NONE) ||
                    dec_in.op == ACX_INVF || (dec_in.op == ACX_INVW && dec_in.ps != AM_DIR));
  wire logic rd_y = st_ff == ST_RDX && dec_ff.op == ACX_ACC && y_on;

  // ----------------------------------------
  // Results
  // ----------------------------------------
  wire logic [39:0] other = dec_ff.acc_b ? acc_a_ff : acc_b_ff; // RL6
  // Convergent: ties round toward the even result
  wire logic rnd_up = other[15] && (other[14:0] != 15'h0 || other[16]);
  wire logic [15:0] wb_round = other[31:16] + {15'h0, rnd_up}; // RL5
  wire logic [15:0] src_val = (dec_ff.op == ACX_INVW && dec_ff.ps == AM_DIR) ?
                              w_ff[dec_ff.sreg] : opa_ff;
  wire logic [15:0] inv_res = ~src_val;
  wire logic res_neg = dec_ff.byte_m ? inv_res[7] : inv_res[15]; // RL11
  wire logic res_zero = inv_res[7:0] == 8'h00 && (dec_ff.byte_m || inv_res[15:8] == 8'h00);
  wire logic wr_m = do_acc && wb_ind || do_invf && dec_ff.dest_f ||
                    do_invw && dec_ff.qd != AM_DIR;
  wire logic [15:0] wr_addr = dec_ff.op == ACX_ACC ? w_ff[W_WB] :
                              dec_ff.op == ACX_INVF ? {3'b000, dec_ff.fadr} :
                              am_ea(dec_ff.qd, dec_ff.byte_m, w_ff[dec_ff.dreg]);
  wire logic [15:0] wr_data = dec_ff.op == ACX_ACC ? wb_round :
                              dec_ff.byte_m ? {inv_res[7:0], inv_res[7:0]} : inv_res;
  wire logic [15:0] m_addr = wr_m ? wr_addr : rd_y ? ya : rx_addr;
  wire logic m_byte = wr_m ? dec_ff.byte_m : !rd_y && dec_in.byte_m;
  wire logic [1:0] m_be = !m_byte ? 2'b11 : m_addr[0] ? 2'b10 : 2'b01;
  assign nxt_mem = {rd_x || rd_y, wr_m, m_be, m_addr, wr_m ? wr_data : 16'h0000};

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      MEM_REQ <= '0;
      lane_ff <= 1'b0;
      opa_ff <= 16'h0000;
      opb_ff <= 16'h0000;
    end else begin
      MEM_REQ <= nxt_mem;
      if (accept) begin
        lane_ff <= rx_addr[0];
      end
      if (st_ff == ST_RDX) begin
        opa_ff <= (dec_ff.byte_m && lane_ff) ? {8'h00, MEM_RDATA[15:8]} : MEM_RDATA;
      end
      if (st_ff == ST_RDY) begin
        opb_ff <= MEM_RDATA;
      end
    end
  end

  // ----------------------------------------
  // Register bus decode
  // ----------------------------------------
  wire logic w_hit = BUS_ADDR[7:6] == `ACX_DEFAULT_WORK_REG_PAGE && BUS_ADDR[1:0] == 2'b00;
  wire logic [3:0] w_idx = BUS_ADDR[5:2];
  wire logic wr_sr = BUS_WR && BUS_ADDR == `ACX_STATUS;
  wire logic wr_cfg = BUS_WR && BUS_ADDR == `ACX_WDT_CFG;

  always_comb begin
    rd_mux = 16'h0000;
    if (w_hit) begin
      rd_mux = w_ff[w_idx];
    end else begin
      case (BUS_ADDR)
        `ACX_STATUS: rd_mux = {10'h0, sr_ff};
        `ACX_WDT_CFG: rd_mux = {12'h0, cfg_ff};
        `ACX_WDT_CNT: rd_mux = wdt_cnt_ff;
        `ACX_WDT_PRE: rd_mux = {6'h0, prb_ff, pra_ff};
        `ACX_FIRST_ACCUMULATOR_L: rd_mux = acc_a_ff[15:0];
        `ACX_FIRST_ACCUMULATOR_M: rd_mux = acc_a_ff[31:16];
        `ACX_FIRST_ACCUMULATOR_U: rd_mux = {8'h00, acc_a_ff[39:32]};
        `ACX_SECOND_ACCUMULATOR_L: rd_mux = acc_b_ff[15:0];
        `ACX_SECOND_ACCUMULATOR_M: rd_mux = acc_b_ff[31:16];
        `ACX_SECOND_ACCUMULATOR_U: rd_mux = {8'h00, acc_b_ff[39:32]};
        default: rd_mux = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      BUS_RDATA <= 16'h0000;
    end else begin
      BUS_RDATA <= BUS_RD ? rd_mux : 16'h0000;
    end
  end

  // ----------------------------------------
  // Working registers; execution wins over a bus write
  // ----------------------------------------
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      for (int i = 0; i < 16; i++) begin
        w_ff[i] <= 16'h0000;
      end
    end else begin
      if (BUS_WR && w_hit) begin
        w_ff[w_idx] <= BUS_WDATA;
      end
      if (do_acc && x_on) begin
        w_ff[xp] <= w_ff[xp] + pf_step(dec_ff.xop); // RL4
        w_ff[{2'b01, dec_ff.xd}] <= opa_ff; // RL6
      end
      if (do_acc && y_on) begin
        w_ff[yp] <= w_ff[yp] + pf_step(dec_ff.yop); // RL4
        w_ff[{2'b01, dec_ff.yd}] <= opb_ff; // RL6
      end
      if (do_acc && wb_dir) begin
        w_ff[W_WB] <= wb_round; // RL5
      end
      if (do_acc && wb_ind) begin
        w_ff[W_WB] <= w_ff[W_WB] + `ACX_WB_STEP; // RL5
      end
      if (do_invf && !dec_ff.dest_f) begin
        w_ff[W_DEF] <= merge(dec_ff.byte_m, w_ff[W_DEF], inv_res); // RL10 RL14
      end
      if (do_invw) begin
        w_ff[dec_ff.sreg] <= w_ff[dec_ff.sreg] + am_step(dec_ff.ps, dec_ff.byte_m); // RL16
        if (dec_ff.qd == AM_DIR) begin
          w_ff[dec_ff.dreg] <= merge(dec_ff.byte_m, w_ff[dec_ff.dreg], inv_res); // RL16
        end else begin
          w_ff[dec_ff.dreg] <= w_ff[dec_ff.dreg] + am_step(dec_ff.qd, dec_ff.byte_m);
        end
      end
    end
  end

  // ----------------------------------------
  // Accumulators and status
  // ----------------------------------------
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      acc_a_ff <= 40'h0;
      acc_b_ff <= 40'h0;
      sr_ff <= `ACX_SR_RST;
    end else begin
      if (BUS_WR) begin
        case (BUS_ADDR)
          `ACX_FIRST_ACCUMULATOR_L: acc_a_ff[15:0] <= BUS_WDATA;
          `ACX_FIRST_ACCUMULATOR_M: acc_a_ff[31:16] <= BUS_WDATA;
          `ACX_FIRST_ACCUMULATOR_U: acc_a_ff[39:32] <= BUS_WDATA[7:0];
          `ACX_SECOND_ACCUMULATOR_L: acc_b_ff[15:0] <= BUS_WDATA;
          `ACX_SECOND_ACCUMULATOR_M: acc_b_ff[31:16] <= BUS_WDATA;
          `ACX_SECOND_ACCUMULATOR_U: acc_b_ff[39:32] <= BUS_WDATA[7:0];
          default: ;
        endcase
      end
      if (wr_sr) begin
        sr_ff <= BUS_WDATA[5:0];
      end
      if (do_acc && !dec_ff.acc_b) begin
        acc_a_ff <= 40'h0; // RL1
        sr_ff.ovf_a <= 1'b0; // RL2
        sr_ff.clip_a <= 1'b0; // RL2
      end
      if (do_acc && dec_ff.acc_b) begin
        acc_b_ff <= 40'h0; // RL1
        sr_ff.ovf_b <= 1'b0; // RL2
        sr_ff.clip_b <= 1'b0; // RL2
      end
      if (do_invf || do_invw) begin
        sr_ff.neg <= res_neg; // RL12
        sr_ff.zero <= res_zero; // RL12
      end
    end
  end

  // ----------------------------------------
  // Watchdog counters
  // ----------------------------------------
  // Ratio settings change only by a bus write, never by a restart
  wire logic [6:0] pra_top = cfg_ff[0] ? `ACX_PRA_LONG : `ACX_PRA_SHORT;
  wire logic pra_wrap = pra_ff == pra_top;
  wire logic prb_wrap = pra_wrap && prb_ff == cfg_ff[3:1];

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      cfg_ff <= `ACX_WDT_CFG_RST;
      pra_ff <= 7'h00;
      prb_ff <= 3'h0;
      wdt_cnt_ff <= 16'h0000;
    end else begin
      if (wr_cfg) begin
        cfg_ff <= BUS_WDATA[3:0]; // RL8
      end
      if (wdt_clear) begin
        pra_ff <= 7'h00; // RL7
        prb_ff <= 3'h0; // RL7
        wdt_cnt_ff <= 16'h0000; // RL7
      end else begin
        pra_ff <= pra_wrap ? 7'h00 : pra_ff + 7'h01;
        prb_ff <= prb_wrap ? 3'h0 : pra_wrap ? prb_ff + 3'h1 : prb_ff;
        wdt_cnt_ff <= prb_wrap ? wdt_cnt_ff + 16'h0001 : wdt_cnt_ff;
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_ACC_ZERO: assert property (@(posedge MCLK) disable iff (!RST_B) // RL1
    do_acc && !dec_ff.acc_b && !BUS_WR |=> acc_a_ff == 40'h0 && $stable(acc_b_ff))
    else $error("selected accumulator not cleared");
  AST_ACC_FLAGS: assert property (@(posedge MCLK) disable iff (!RST_B) // RL2
    do_acc && dec_ff.acc_b && !BUS_WR |=> !sr_ff.ovf_b && !sr_ff.clip_b &&
    sr_ff.ovf_a == $past(sr_ff.ovf_a) && sr_ff.clip_a == $past(sr_ff.clip_a))
    else $error("accumulator flags wrong after clear");
  AST_ACC_SEQ: assert property (@(posedge MCLK) disable iff (!RST_B) // RL3
    accept && INSTR[23:16] == `ACX_OPC_ACC && !INSTR[14] |=>
    st_ff == ST_RDX ##1 st_ff == ST_RDY ##1 in_exec ##1 INSTR_READY)
    else $error("accumulator clear not sequenced");
  AST_PREFETCH: assert property (@(posedge MCLK) disable iff (!RST_B) // RL4
    do_acc && x_on && !BUS_WR |=> w_ff[{2'b01, dec_ff.xd}] == $past(opa_ff) &&
    w_ff[xp] == $past(w_ff[xp]) + $past(pf_step(dec_ff.xop)))
    else $error("X prefetch wrong");
  AST_WB_MEM: assert property (@(posedge MCLK) disable iff (!RST_B) // RL5
    do_acc && wb_ind && !BUS_WR |=> MEM_REQ.wr && MEM_REQ.addr == $past(w_ff[W_WB]) &&
    MEM_REQ.wdata == $past(wb_round) && w_ff[W_WB] == $past(w_ff[W_WB]) + 16'h0002)
    else $error("indirect write-back wrong");
  AST_WB_SRC: assert property (@(posedge MCLK) disable iff (!RST_B) // RL6
    do_acc && wb_dir && !BUS_WR |=>
    (w_ff[W_WB] - $past(other[31:16])) inside {16'h0000, 16'h0001})
    else $error("write-back source wrong");
  AST_WDT_CLEAR: assert property (@(posedge MCLK) disable iff (!RST_B) // RL7
    wdt_clear && !BUS_WR |=> wdt_cnt_ff == 16'h0000 && pra_ff == 7'h00 &&
    prb_ff == 3'h0 && $stable(sr_ff))
    else $error("watchdog restart incomplete");
  AST_WDT_CFG: assert property (@(posedge MCLK) disable iff (!RST_B) // RL8
    wdt_clear && !BUS_WR |=> $stable(cfg_ff))
    else $error("prescaler settings changed");
  AST_WDT_ONE: assert property (@(posedge MCLK) disable iff (!RST_B) // RL9
    wdt_clear |=> INSTR_READY && EXEC_DONE)
    else $error("watchdog restart not one cycle");
  AST_INVF_W0: assert property (@(posedge MCLK) disable iff (!RST_B) // RL10
    do_invf && !dec_ff.dest_f && !dec_ff.byte_m && !BUS_WR |=> w_ff[W_DEF] == ~$past(opa_ff))
    else $error("file inversion to W0 wrong");
  AST_BYTE_KEEP: assert property (@(posedge MCLK) disable iff (!RST_B) // RL11
    do_invf && !dec_ff.dest_f && dec_ff.byte_m && !BUS_WR |=>
    w_ff[W_DEF][15:8] == $past(w_ff[W_DEF][15:8]))
    else $error("byte inversion touched high byte");
  AST_NZ: assert property (@(posedge MCLK) disable iff (!RST_B) // RL12
    (do_invf || do_invw) && !BUS_WR |=> sr_ff.zero == $past(res_zero) &&
    sr_ff.neg == $past(res_neg) && sr_ff[5:2] == $past(sr_ff[5:2]))
    else $error("inversion flags wrong");
  AST_INVF_ADDR: assert property (@(posedge MCLK) disable iff (!RST_B) // RL13
    accept && dec_in.op == ACX_INVF |=> MEM_REQ.rd && MEM_REQ.addr == {3'b000, $past(INSTR[12:0])})
    else $error("file address wrong");
  AST_INV_TIME: assert property (@(posedge MCLK) disable iff (!RST_B) // RL15
    accept && dec_in.op == ACX_INVF |-> ##3 in_exec ##1 (INSTR_READY && EXEC_DONE))
    else $error("file inversion timing wrong");
  AST_INVW_DIR: assert property (@(posedge MCLK) disable iff (!RST_B) // RL16
    do_invw && dec_ff.ps == AM_DIR && dec_ff.qd == AM_DIR && !dec_ff.byte_m && !BUS_WR |=>
    w_ff[dec_ff.dreg] == ~$past(w_ff[dec_ff.sreg]))
    else $error("register inversion wrong");
  AST_NO_SIDE: assert property (@(posedge MCLK) disable iff (!RST_B) // RL17
    do_acc && !x_on && !y_on && !wb_dir && !wb_ind && !BUS_WR |=>
    !MEM_REQ.wr && $stable(w_ff[4]) && $stable(w_ff[8]) && $stable(w_ff[W_WB]))
    else $error("plain clear had side effects");
endmodule
`default_nettype wire

// ### logic/acx_map.svh
/* Offsets, reset values, opcodes and counts for the acx block.
   Assumes inclusion by its bare name, after the package. */
`ifndef ACX_MAP_SVH
`define ACX_MAP_SVH
// ----------------------------------------
// Register offsets, W0..W15 at base + 4n
// ----------------------------------------
`define ACX_STATUS 8'h00
`define ACX_WDT_CFG 8'h04
`define ACX_WDT_CNT 8'h08
`define ACX_WDT_PRE 8'h0C
`define ACX_FIRST_ACCUMULATOR_L 8'h10
`define ACX_FIRST_ACCUMULATOR_M 8'h14
`define ACX_FIRST_ACCUMULATOR_U 8'h18
`define ACX_SECOND_ACCUMULATOR_L 8'h1C
`define ACX_SECOND_ACCUMULATOR_M 8'h20
`define ACX_SECOND_ACCUMULATOR_U 8'h24
`define ACX_DEFAULT_WORK_REG_PAGE 2'h1
// ----------------------------------------
// Reset values
// ----------------------------------------
`define ACX_WDT_CFG_RST 4'h0
`define ACX_SR_RST 6'h00
// ----------------------------------------
// Opcodes and field codes
// ----------------------------------------
`define ACX_OPC_ACC 8'hC3
`define ACX_OPC_WDT 24'hFE6000
`define ACX_OPC_INVF 8'hEE
`define ACX_OPC_INVW 8'hEA
`define ACX_PF_NONE 4'h4
`define ACX_PF_REG 4'hC
`define ACX_WB_DIR 2'h0
`define ACX_WB_IND 2'h1
`define ACX_WB_STEP 16'h0002
// ----------------------------------------
// Watchdog prescaler A terminal counts
// ----------------------------------------
`define ACX_PRA_SHORT 7'h1F
`define ACX_PRA_LONG 7'h7F
`endif

// ### logic/acx_pkg.sv
/* Types shared by the acx decoder and core.
   Assumes nothing beyond a SystemVerilog compiler. */
`default_nettype none
package acx_pkg;
  typedef enum logic [2:0] {ACX_NONE, ACX_ACC, ACX_WDT, ACX_INVF, ACX_INVW} acx_op_e;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_RDX = 2'b01, ST_RDY = 2'b11, ST_EXEC = 2'b10
  } acx_state_e;
  typedef struct packed {
    acx_op_e op;
    logic acc_b;
    logic [1:0] xd;
    logic [1:0] yd;
    logic [3:0] xop;
    logic [3:0] yop;
    logic [1:0] wb;
    logic byte_m;
    logic dest_f;
    logic [12:0] fadr;
    logic [2:0] qd;
    logic [3:0] dreg;
    logic [2:0] ps;
    logic [3:0] sreg;
  } acx_dec_s;
  typedef struct packed {
    logic clip_b;
    logic clip_a;
    logic ovf_b;
    logic ovf_a;
    logic neg;
    logic zero;
  } acx_sr_s;
  typedef struct packed {
    logic rd;
    logic wr;
    logic [1:0] be;
    logic [15:0] addr;
    logic [15:0] wdata;
  } acx_mem_s;
endpackage
`default_nettype wire

// ### logic/acx_decode.sv
/* acx_decode: splits a 24-bit instruction word into class and fields.
   Assumes the word is stable while the core samples it. */
`include "acx_map.svh"
`timescale 1ns/100ps
`default_nettype none
module acx_decode import acx_pkg::*; (
  input wire logic [23:0] instr,
  output var acx_dec_s dec
);
  // ----------------------------------------
  // Class match
  // ----------------------------------------
  wire logic hit_acc = instr[23:16] == `ACX_OPC_ACC && !instr[14]; // RL3
  wire logic hit_wdt = instr == `ACX_OPC_WDT; // RL9
  wire logic hit_invf = instr[23:15] == {`ACX_OPC_INVF, 1'b1}; // RL13
  wire logic hit_invw = instr[23:15] == {`ACX_OPC_INVW, 1'b1};
  acx_op_e op;
  assign op = hit_acc ? ACX_ACC : hit_wdt ? ACX_WDT : hit_invf ? ACX_INVF :
              hit_invw ? ACX_INVW : ACX_NONE;
  // ----------------------------------------
  // Fields overlap; each class reads its own
  // ----------------------------------------
  assign dec = {op, instr[15], instr[13:0], instr[14:13], instr[12:0], instr[13:0]}; // RL6
endmodule
`default_nettype wire

// ### test/acx_mem_model.sv
/* Data memory stand-in for acx_core.
   Assumes one read in flight, answered in the cycle in which rd stands. */
`timescale 1ns/100ps
`default_nettype none
module acx_mem_model import acx_pkg::*; (
  input wire logic clk,
  input wire logic rst_b,
  input wire acx_mem_s req,
  output logic [15:0] rdata
);
  logic [15:0] idle_ff;
  // Core samples read data at the edge that ends its rd cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      idle_ff <= 16'h0000;
    end else begin
      idle_ff <= ~idle_ff;
    end
  end
  // Word at a reads a ^ 5A5A; toggling between answers exposes late sampling
  assign rdata = req.rd ? req.addr ^ 16'h5A5A : idle_ff;
endmodule
`default_nettype wire

// ### test/acx_core_test.sv
/* acx_core_test: directed bench for acx_core over its register port.
   Assumes acx_pkg, acx_map.svh and the memory stand-in are compiled. */
`include "acx_map.svh"
`timescale 1ns/100ps
`default_nettype none
module acx_core_test import acx_pkg::*;;
  logic mclk = 1'b0, rst_b = 1'b0, iv = 1'b0, bwr = 1'b0, brd = 1'b0;
  logic [23:0] instr = 24'h000000;
  logic [7:0] badr = 8'h00;
  logic [15:0] bwd = 16'h0000;
  logic ird, done;
  logic [15:0] brdata, mrd, wa, wd;
  logic [1:0] wbe;
  acx_mem_s mreq;
  int err_count = 0, samples_checked = 0, nmem = 0;
  always #12.5 mclk = ~mclk;
  acx_core acx_core_i (.MCLK(mclk), .RST_B(rst_b), .INSTR_VALID(iv), .INSTR(instr),
    .INSTR_READY(ird), .EXEC_DONE(done), .MEM_REQ(mreq), .MEM_RDATA(mrd),
    .BUS_ADDR(badr), .BUS_WDATA(bwd), .BUS_WR(bwr), .BUS_RD(brd), .BUS_RDATA(brdata));
  acx_mem_model acx_mem_model_i (.clk(mclk), .rst_b(rst_b), .req(mreq), .rdata(mrd));
  always @(posedge mclk) begin
    if (mreq.rd || mreq.wr) nmem++;
    if (mreq.wr) {wa, wd, wbe} = {mreq.addr, mreq.wdata, mreq.be};
  end
  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic summarize();
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    samples_checked++;
    if (s !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    {badr, bwd, bwr} <= {a, d, 1'b1};
    @(posedge mclk);
    bwr <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [15:0] e);
    @(posedge mclk);
    {badr, brd} <= {a, 1'b1};
    @(posedge mclk);
    brd <= 1'b0;
    #1 chk($sformatf("reg %h", a), brdata, e);
  endtask
  // Counts edges from the taking edge to the done pulse
  task automatic ex(input logic [23:0] i, input logic [15:0] cyc);
    int c;
    c = 1;
    @(posedge mclk);
    {instr, iv} <= {i, 1'b1};
    @(posedge mclk);
    iv <= 1'b0;
    #1;
    while (done !== 1'b1 && c < 20) begin
      @(posedge mclk);
      #1 c++;
    end
    chk("cycles", c[15:0], cyc);
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge mclk);
    rst_b <= 1'b1;
    wr(8'h30, 16'hFFFF);
    rc(8'h30, 16'h0000);
    wr(`ACX_FIRST_ACCUMULATOR_L, 16'hFFFF);
    wr(`ACX_FIRST_ACCUMULATOR_M, 16'hFFFF);
    wr(`ACX_FIRST_ACCUMULATOR_U, 16'h00FF);
    wr(`ACX_SECOND_ACCUMULATOR_L, 16'h1234);
    wr(`ACX_STATUS, 16'h003F);
    wr(8'h50, 16'hBEEF);
    nmem = 0;
    ex(24'hC30112, 16'h4);
    // A store would show in the same cycle as done, counted at the next edge
    @(posedge mclk);
    #1;
    chk("mem ops", nmem[15:0], 16'h0000);
    rc(`ACX_FIRST_ACCUMULATOR_L, 16'h0000);
    rc(`ACX_FIRST_ACCUMULATOR_M, 16'h0000);
    rc(`ACX_FIRST_ACCUMULATOR_U, 16'h0000);
    rc(`ACX_SECOND_ACCUMULATOR_L, 16'h1234);
    rc(`ACX_STATUS, 16'h002B);
    rc(8'h50, 16'hBEEF);
    wr(8'h60, 16'h2000);
    wr(8'h68, 16'h3000);
    wr(8'h74, 16'h4000);
    wr(`ACX_FIRST_ACCUMULATOR_L, 16'h2345);
    wr(`ACX_FIRST_ACCUMULATOR_M, 16'h0067);
    wr(`ACX_FIRST_ACCUMULATOR_U, 16'h0000);
    wr(`ACX_STATUS, 16'h003F);
    ex(24'hC3AC45, 16'h4);
    rc(8'h58, 16'h7A5A);
    rc(8'h5C, 16'h6A5A);
    rc(8'h60, 16'h2002);
    rc(8'h68, 16'h3002);
    rc(8'h74, 16'h4002);
    rc(`ACX_SECOND_ACCUMULATOR_L, 16'h0000);
    rc(`ACX_STATUS, 16'h0017);
    chk("store addr", wa, 16'h4000);
    chk("store data", wd, 16'h0067);
    // Tie on the rounding boundary, odd upper word
    wr(`ACX_SECOND_ACCUMULATOR_M, 16'h5421);
    wr(`ACX_SECOND_ACCUMULATOR_L, 16'h8000);
    ex(24'hC30150, 16'h4);
    rc(8'h50, 16'h7A58);
    rc(8'h60, 16'h1FFC);
    rc(8'h74, 16'h5422);
    wr(`ACX_WDT_CFG, 16'h0002);
    wr(`ACX_STATUS, 16'h0015);
    repeat (200) @(posedge mclk);
    ex(24'hFE6000, 16'h1);
    rc(`ACX_WDT_PRE, 16'h0001);
    rc(`ACX_WDT_CNT, 16'h0000);
    rc(`ACX_WDT_CFG, 16'h0002);
    rc(`ACX_STATUS, 16'h0015);
    ex(24'hEE9FFE, 16'h4);
    rc(8'h40, 16'hBA5B);
    rc(`ACX_STATUS, 16'h0016);
    ex(24'hEEEA5A, 16'h4);
    @(posedge mclk);
    #1;
    chk("inv addr", wa, 16'h0A5A);
    chk("inv data", wd, 16'hFFFF);
    chk("inv lanes", {14'h0, wbe}, 16'h0001);
    // Byte from an odd address into W0, high byte kept
    ex(24'hEECA5B, 16'h4);
    rc(8'h40, 16'hBAAF);
    for (int k = 0; k < 2; k++) begin
      wr(8'h4C, k ? 16'hFFFF : 16'h0000);
      wr(`ACX_STATUS, 16'h0000);
      ex(24'hEA8483, 16'h4);
      rc(8'h64, k ? 16'h0000 : 16'hFFFF);
      rc(`ACX_STATUS, k ? 16'h0001 : 16'h0002);
    end
    summarize();
  end
  initial begin
    repeat (4000) @(posedge mclk);
    err_count++;
    summarize();
  end
endmodule
`default_nettype wire
